// ### verilog/asrr_pkg.sv
// Purpose: Constants and types for the converter serial readout block
// Assumes: 200 MHz sys_clk, synchronous active-high reset
// Notes:   Conversion clock and link pins are sampled, not used as clocks
package asrr_pkg;
   localparam int          DATA_W        = 24;
   localparam logic [7:0]  READ_DATA_CMD = 8'h12;
   localparam int          LATE_CYCLES   = 16;
   localparam logic [23:0] CODE_POS_FS   = 24'h7fffff;
   localparam logic [23:0] CODE_NEG_FS   = 24'h800000;
   localparam logic [7:0]  CRC_POLY      = 8'h07;
   localparam logic [7:0]  CRC_INIT      = 8'h00;
   localparam int          NEW_BIT_POS   = 6;
   localparam logic [5:0]  FRAME_BITS_ST = 6'd40;
   localparam logic [5:0]  FRAME_BITS_NS = 6'd32;
   localparam logic [23:0] BUF_RESET     = 24'h000000;
   localparam logic [15:0] CONV_CNT_RST  = 16'h0000;

   typedef enum logic [1:0] {
      ASRR_LK_IDLE,
      ASRR_LK_CMD,
      ASRR_LK_READ,
      ASRR_LK_SKIP
   } asrr_link_t;
endpackage

// ### verilog/asrr_core.sv
// Purpose: Serial readout, data-ready pins and result buffer of the ADC
// Assumes: Link pins and conversion clock asynchronous to sys_clk
// Notes:   Register commands other than read-data are passed out raw
`timescale 1ns/100ps

module asrr_sync3 #(
   parameter logic INIT = 1'b0
) (
   input  wire logic sys_clk, // System clock
   input  wire logic srst,    // Synchronous reset
   input  wire logic d,       // Asynchronous input
   output logic      q        // Filtered level
);
   logic [2:0] s_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_q <= {3{INIT}};
         q   <= INIT;
      end else begin
         s_q <= {s_q[1:0], d};
         if (s_q[1] == s_q[2]) begin
            q <= s_q[2];
         end
      end
   end
endmodule

module asrr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk,   // System clock
   input  wire logic             srst,      // Synchronous reset
   input  wire logic             in_valid,  // Write request
   output logic                  in_ready,  // Not full
   input  wire logic [WIDTH-1:0] in_data,   // Write word
   output logic                  out_valid, // Not empty
   input  wire logic             out_ready, // Read accept
   output logic      [WIDTH-1:0] out_data   // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;
   assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q[AW-1:0]];
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule

module asrr_core
   import asrr_pkg::*;
#(
   parameter int RAW_W       = 26,
   parameter int CONV_CYCLES = 256,
   parameter int FIFO_DEPTH  = 4
) (
   input  wire logic             sys_clk,                 // 200 MHz clock
   input  wire logic             srst,                    // Sync reset
   input  wire logic             sclk_pin,                // Shift clock
   input  wire logic             din_pin,                 // Serial in
   input  wire logic             converter_select_n,      // Select ADC
   input  wire logic             amplifier_select_n,      // Select PGA
   input  wire logic             conversion_clock,        // Conv clock
   input  wire logic             conv_start,              // Start pulse
   input  wire logic             continuous_mode,         // 1 continuous
   input  wire logic             status_append_enable,    // Send status
   input  wire logic [7:0]       status_bits,             // Status source
   input  wire logic             raw_valid,               // Result valid
   output logic                  raw_ready,               // Result taken
   input  wire logic [RAW_W-1:0] raw_data,                // Signed result
   output logic                  shared_out_ready_pin_o,  // Pin level
   output logic                  shared_out_ready_pin_oe, // Pin drive
   output logic                  result_ready_n,          // Ready pin
   output logic                  new_data,                // New flag
   output logic      [7:0]       rx_byte,                 // Received byte
   output logic                  rx_valid                 // Byte pulse
);
   import asrr_pkg::*;

   logic sclk_l, din_l, csc_n_l, csa_n_l, conversion_clock_l;
   logic sclk_p_q, conversion_clock_p_q;
   asrr_sync3 #(.INIT(1'b0)) u_sclk (.sys_clk(sys_clk), .srst(srst),
      .d(sclk_pin), .q(sclk_l));
   asrr_sync3 #(.INIT(1'b0)) u_din (.sys_clk(sys_clk), .srst(srst),
      .d(din_pin), .q(din_l));
   asrr_sync3 #(.INIT(1'b1)) u_csc (.sys_clk(sys_clk), .srst(srst),
      .d(converter_select_n), .q(csc_n_l));
   asrr_sync3 #(.INIT(1'b1)) u_csa (.sys_clk(sys_clk), .srst(srst),
      .d(amplifier_select_n), .q(csa_n_l));
   asrr_sync3 #(.INIT(1'b0)) u_conversion_clock (.sys_clk(sys_clk), .srst(srst),
      .d(conversion_clock), .q(conversion_clock_l));

   // Edge detection on the filtered levels
   wire sclk_rise = sclk_l && !sclk_p_q;
   wire sclk_fall = !sclk_l && sclk_p_q;
   wire conversion_clock_rise = conversion_clock_l && !conversion_clock_p_q;
   wire selected  = !csc_n_l;

   // Saturate the raw converter word to 24 bits
   wire [RAW_W-DATA_W:0] raw_hi = raw_data[RAW_W-1:DATA_W-1];
   wire in_range  = (raw_hi == '0) || (raw_hi == '1);
   wire [DATA_W-1:0] clip_data = in_range ? raw_data[DATA_W-1:0] :
      (raw_data[RAW_W-1] ? CODE_NEG_FS : CODE_POS_FS);

   logic              fifo_valid;
   logic [DATA_W-1:0] fifo_data;
   logic              latch;
   asrr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .in_valid (raw_valid),
      .in_ready (raw_ready),
      .in_data  (clip_data),
      .out_valid(fifo_valid),
      .out_ready(latch),
      .out_data (fifo_data)
   );

   asrr_link_t        st_q, st_d;
   logic [7:0]        rx_sr_q;
   logic [2:0]        rx_cnt_q;
   logic [39:0]       tx_sr_q;
   logic [5:0]        tx_cnt_q;
   logic [5:0]        tx_len_q;
   logic              out_bit_q;
   logic [DATA_W-1:0] buf_q;
   logic [15:0]       conv_cnt_q;
   logic              rdy_n_q, new_q;

   wire [7:0] rx_next    = {rx_sr_q[6:0], din_l};
   wire       byte_done  = sclk_fall && (rx_cnt_q == 3'd7);
   wire       read_start = selected && byte_done && (st_q == ASRR_LK_CMD)
                           && (rx_next == READ_DATA_CMD);
   wire       reading    = (st_q == ASRR_LK_READ);
   wire       read_end   = reading && sclk_fall && (tx_cnt_q == tx_len_q);
   // Buffer loads only outside a read or on its final falling edge, so a frame never mixes results
   assign latch = fifo_valid && (!reading || read_end) && !read_start
                  || fifo_valid && read_start && !rdy_n_q;

   wire late_win = continuous_mode && new_q &&
      (conv_cnt_q >= 16'(CONV_CYCLES - LATE_CYCLES));

   // Snapshot: a result arriving with the command while ready is low is sent as new
   wire [DATA_W-1:0] snap_data = latch ? fifo_data : buf_q;
   wire              snap_new  = latch || new_q;
   wire [7:0] snap_stat = {status_bits[7], snap_new, status_bits[5:0]};
   wire [31:0] payload = status_append_enable ? {snap_stat, snap_data}
                         : {snap_data, 8'h00};
   wire [5:0]  plen    = status_append_enable ? 6'd32 : 6'd24;

   function automatic logic [7:0] crc8(input logic [31:0] p,
                                       input logic [5:0] n);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 32; i++) begin
         if (6'(i) < n) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ p[31-i]) ? CRC_POLY : 8'h00);
         end
      end
      return c;
   endfunction

   wire [7:0] frame_crc = crc8(payload, plen);
   wire [39:0] frame = status_append_enable ? {payload, frame_crc}
                       : {payload[31:8], frame_crc, 8'h00};

   always_comb begin
      st_d = st_q;
      case (st_q)
         ASRR_LK_IDLE: if (selected) st_d = ASRR_LK_CMD;
         ASRR_LK_CMD: begin
            if (read_start) begin
               st_d = ASRR_LK_READ;
            end else if (byte_done) begin
               st_d = ASRR_LK_SKIP;
            end
         end
         ASRR_LK_READ: if (read_end) st_d = ASRR_LK_SKIP;
         ASRR_LK_SKIP: st_d = ASRR_LK_SKIP;
         default:      st_d = ASRR_LK_IDLE;
      endcase
      if (!selected) begin
         st_d = ASRR_LK_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q      <= ASRR_LK_IDLE;
         sclk_p_q  <= 1'b0;
         conversion_clock_p_q  <= 1'b0;
         rx_sr_q   <= 8'h00;
         rx_cnt_q  <= 3'd0;
         rx_valid  <= 1'b0;
         rx_byte   <= 8'h00;
      end else begin
         st_q     <= st_d;
         sclk_p_q <= sclk_l;
         conversion_clock_p_q <= conversion_clock_l;
         rx_valid <= 1'b0;
         if (!selected) begin
            rx_cnt_q <= 3'd0;
         end else if (sclk_fall) begin
            rx_sr_q  <= rx_next;
            rx_cnt_q <= rx_cnt_q + 3'd1;
            if (rx_cnt_q == 3'd7) begin
               rx_byte  <= rx_next;
               rx_valid <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tx_sr_q   <= '0;
         tx_cnt_q  <= 6'd0;
         tx_len_q  <= FRAME_BITS_NS;
         out_bit_q <= 1'b1;
      end else if (read_start) begin
         tx_sr_q  <= frame;
         tx_cnt_q <= 6'd0;
         tx_len_q <= status_append_enable ? FRAME_BITS_ST : FRAME_BITS_NS;
      end else if (reading && sclk_rise) begin
         out_bit_q <= tx_sr_q[39];
         tx_sr_q   <= {tx_sr_q[38:0], 1'b0};
         tx_cnt_q  <= tx_cnt_q + 6'd1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         buf_q      <= BUF_RESET;
         conv_cnt_q <= CONV_CNT_RST;
         rdy_n_q    <= 1'b1;
         new_q      <= 1'b0;
      end else begin
         if (latch) begin
            buf_q <= fifo_data;
         end
         if (conv_start || latch) begin
            conv_cnt_q <= CONV_CNT_RST;
         end else if (conversion_clock_rise && conv_cnt_q != 16'hffff) begin
            conv_cnt_q <= conv_cnt_q + 16'd1;
         end
         if (latch && !read_start) begin
            new_q <= 1'b1;
         end else if (read_start) begin
            new_q <= 1'b0;
         end
         if (latch && !read_start) begin
            rdy_n_q <= 1'b0;
         end else if (conv_start) begin
            rdy_n_q <= 1'b1;
         end else if (continuous_mode && (reading || read_start)) begin
            rdy_n_q <= 1'b1;
         end else if (late_win) begin
            rdy_n_q <= 1'b1;
         end
      end
   end

   assign result_ready_n = rdy_n_q;
   assign new_data       = new_q;
   // Pin: data while reading, ready while selected, driven high while only the PGA is selected, else released
   assign shared_out_ready_pin_oe = !(csc_n_l && csa_n_l);
   assign shared_out_ready_pin_o  = reading ? out_bit_q :
      (selected ? rdy_n_q : 1'b1);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_cmd_taken;
      read_start;
   endsequence
   sequence s_frame_done;
      read_end ##1 !reading;
   endsequence

   property p_tristate;
      csc_n_l && csa_n_l |-> !shared_out_ready_pin_oe;
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("shared pin driven while deselected");

   property p_idle_ready;
      selected && !reading |-> shared_out_ready_pin_o == result_ready_n;
   endproperty
   a_idle_ready: assert property (p_idle_ready)
      else $error("shared pin not showing ready");

   property p_read_out;
      s_cmd_taken |=> reading ##0 shared_out_ready_pin_o == out_bit_q;
   endproperty
   a_read_out: assert property (p_read_out)
      else $error("shared pin not carrying data");

   property p_holdoff;
      reading && !read_end |-> !latch;
   endproperty
   a_holdoff: assert property (p_holdoff)
      else $error("buffer reloaded during a read");

   property p_fall;
      latch && !read_start |=> !result_ready_n ##0 new_data;
   endproperty
   a_fall: assert property (p_fall)
      else $error("ready did not fall on new result");

   property p_start;
      conv_start && !latch |=> result_ready_n;
   endproperty
   a_start: assert property (p_start)
      else $error("ready not high at conversion start");

   property p_read_high;
      continuous_mode and s_cmd_taken |=> result_ready_n [*2];
   endproperty
   a_read_high: assert property (p_read_high)
      else $error("ready low during readback");

   property p_cleared;
      s_cmd_taken |=> !new_data;
   endproperty
   a_cleared: assert property (p_cleared)
      else $error("new flag kept after read");

   property p_late;
      late_win && !latch |=> result_ready_n;
   endproperty
   a_late: assert property (p_late)
      else $error("no early ready pulse");

   property p_deselect;
      !selected |=> st_q == ASRR_LK_IDLE ##0 rx_cnt_q == 3'd0;
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("link state kept while deselected");

   property p_clip;
      raw_valid && !in_range && !raw_data[RAW_W-1] |->
         clip_data == CODE_POS_FS;
   endproperty
   a_clip: assert property (p_clip)
      else $error("positive overdrive not clipped");

   property p_done;
      s_frame_done |-> st_q == ASRR_LK_SKIP || !selected;
   endproperty
   a_done: assert property (p_done)
      else $error("frame did not end");
endmodule

// ### bench/asrr_host_model.sv
// Purpose: Host side of the readout link, an SPI mode 1 master
// Assumes: Paced from the bench clock, 80 ns shift clock period
// Notes:   Released data line shows the inverse of its last level
`timescale 1ns/100ps

module asrr_host_model (
   input  wire logic sys_clk,            // Pacing clock
   output logic      sclk_pin,           // Shift clock
   output logic      din_pin,            // Serial data to device
   output logic      converter_select_n, // Converter select
   input  wire logic pin_o,              // Shared pin level
   input  wire logic pin_oe              // Shared pin driven
);
   import asrr_pkg::*;

   initial begin
      sclk_pin = 1'b0;
      din_pin = 1'b0;
      converter_select_n = 1'b1;
   end

   task automatic half;
      repeat (8) @(negedge sys_clk);
   endtask

   // New bit on the rise, sample the pin just before the fall
   task automatic bit_io(input logic b, output logic s);
      sclk_pin = 1'b1;
      din_pin = b;
      half();
      s = pin_oe ? pin_o : 1'bx;
      sclk_pin = 1'b0;
      half();
   endtask

   task automatic sel(input logic v);
      @(negedge sys_clk);
      converter_select_n = v;
   endtask

   task automatic finish_sel;
      din_pin = ~din_pin;
      converter_select_n = 1'b1;
      half();
   endtask

   // Aborted command: a few bits, then deselect
   task automatic part(input int nb);
      logic s;
      sel(1'b0);
      half();
      for (int i = 0; i < nb; i++) bit_io(READ_DATA_CMD[7-i], s);
      finish_sel();
   endtask

   task automatic xfer(input int nb, output logic [39:0] got);
      logic s;
      got = '0;
      sel(1'b0);
      half();
      for (int i = 7; i >= 0; i--) bit_io(READ_DATA_CMD[i], s);
      // Repeat the command byte so the last byte taken in is known
      for (int i = 0; i < nb; i++) begin
         bit_io(READ_DATA_CMD[7 - (i % 8)], s);
         got = {got[38:0], s};
      end
      finish_sel();
   endtask
endmodule

// ### bench/asrr_core_tb_top.sv
// Purpose: Self-checking bench for the converter serial readout
// Assumes: Host model drives the link, bench drives results
// Notes:   Conversion period shortened to 32 conversion clocks
`timescale 1ns/100ps

module asrr_core_tb_top;
   import asrr_pkg::*;
   localparam int CONV = 32;
   logic        sys_clk;
   logic        srst;
   logic        sclk_pin;
   logic        din_pin;
   logic        converter_select_n;
   logic        amplifier_select_n;
   logic        conversion_clock;
   logic        conv_start;
   logic        continuous_mode;
   logic        status_append_enable;
   logic [7:0]  status_bits;
   logic        raw_valid;
   logic        raw_ready;
   logic [25:0] raw_data;
   logic        pin_o;
   logic        pin_oe;
   logic        result_ready_n;
   logic        new_data;
   logic [7:0]  rx_byte;
   logic        rx_valid;
   int          n_errors;
   int          total_checks;
   int          n_rx;

   asrr_core #(.CONV_CYCLES(CONV)) asrr_core_inst (
      .sys_clk(sys_clk), .srst(srst), .sclk_pin(sclk_pin),
      .din_pin(din_pin), .converter_select_n(converter_select_n),
      .amplifier_select_n(amplifier_select_n),
      .conversion_clock(conversion_clock), .conv_start(conv_start),
      .continuous_mode(continuous_mode),
      .status_append_enable(status_append_enable),
      .status_bits(status_bits), .raw_valid(raw_valid),
      .raw_ready(raw_ready), .raw_data(raw_data),
      .shared_out_ready_pin_o(pin_o), .shared_out_ready_pin_oe(pin_oe),
      .result_ready_n(result_ready_n), .new_data(new_data),
      .rx_byte(rx_byte), .rx_valid(rx_valid));

   asrr_host_model asrr_host_model_inst (
      .sys_clk(sys_clk), .sclk_pin(sclk_pin), .din_pin(din_pin),
      .converter_select_n(converter_select_n), .pin_o(pin_o),
      .pin_oe(pin_oe));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Count received-byte pulses from the link
   always @(posedge sys_clk) begin
      if (rx_valid === 1'b1) begin
         n_rx <= n_rx + 1;
      end
   end

   initial begin
      conversion_clock = 1'b0;
      #13;
      forever #40 conversion_clock = ~conversion_clock;
   end

   task automatic final_report;
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] crc8(input logic [31:0] d, input int n);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = n * 8 - 1; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
      return c;
   endfunction

   // Start a conversion, hand over one result, wait for ready
   task automatic load(input logic [25:0] v);
      @(negedge sys_clk);
      conv_start = 1'b1;
      @(negedge sys_clk);
      conv_start = 1'b0;
      raw_valid = 1'b1;
      raw_data = v;
      chk(result_ready_n, 1'b1);
      for (int i = 0; i < 50 && raw_ready !== 1'b1; i++)
         @(negedge sys_clk);
      @(negedge sys_clk);
      raw_valid = 1'b0;
      for (int i = 0; i < 60 && result_ready_n !== 1'b0; i++)
         @(negedge sys_clk);
      chk(result_ready_n, 1'b0);
      chk(new_data, 1'b1);
   endtask

   task automatic rd(input logic st, input logic [23:0] exp, input logic nb);
      logic [39:0] f;
      int          n0;
      @(negedge sys_clk);
      status_append_enable = st;
      n0 = n_rx;
      asrr_host_model_inst.xfer(st ? 40 : 32, f);
      chk(n_rx - n0, st ? 32'd6 : 32'd5);
      chk(f[31:8], exp);
      chk(f[7:0], st ? crc8(f[39:8], 4) : crc8({8'h00, f[31:8]}, 3));
      if (st) chk(f[39:32], {1'b1, nb, 6'h25});
      chk(new_data, 1'b0);
      chk(rx_byte, READ_DATA_CMD);
      chk(result_ready_n, continuous_mode);
   endtask

   task automatic t_unread;
      int n;
      continuous_mode = 1'b1;
      load(26'h0000123);
      n = 0;
      while (result_ready_n === 1'b0 && n < 40) begin
         @(posedge conversion_clock);
         n++;
      end
      chk(n >= 15 && n <= 18, 1'b1);
      rd(1'b1, 24'h000123, 1'b1);
      rd(1'b1, 24'h000123, 1'b0);
   endtask

   task automatic t_sel;
      continuous_mode = 1'b0;
      load(26'h0000000);
      asrr_host_model_inst.sel(1'b0);
      repeat (8) @(negedge sys_clk);
      chk({pin_oe, pin_o}, 2'b10);
      asrr_host_model_inst.sel(1'b1);
      amplifier_select_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk({pin_oe, result_ready_n}, 2'b10);
      amplifier_select_n = 1'b1;
      repeat (8) @(negedge sys_clk);
      chk(pin_oe, 1'b0);
      asrr_host_model_inst.part(3);
      rd(1'b0, 24'h000000, 1'b1);
   endtask

   task automatic t_codes;
      logic [25:0] raw [4];
      logic [23:0] exp [4];
      raw = '{26'h0000001, 26'h3ffffff, 26'h1000000, 26'h2000000};
      exp = '{24'h000001, 24'hffffff, 24'h7fffff, 24'h800000};
      for (int i = 0; i < 4; i++) begin
         load(raw[i]);
         rd(1'b1, exp[i], 1'b1);
      end
   endtask

   // Results arrive while a read runs: buffer holds, FIFO fills
   task automatic t_fifo;
      logic [39:0] f;
      load(26'h0000456);
      status_append_enable = 1'b0;
      fork
         asrr_host_model_inst.xfer(32, f);
         begin
            repeat (200) @(negedge sys_clk);
            raw_valid = 1'b1;
            for (int i = 1; i <= 4; i++) begin
               raw_data = 26'(i * 3);
               @(negedge sys_clk);
            end
            chk(raw_ready, 1'b0);
            raw_valid = 1'b0;
         end
      join
      chk(f[31:8], 24'h000456);
      repeat (20) @(negedge sys_clk);
      rd(1'b0, 24'h00000c, 1'b1);
   endtask

   initial begin
      srst = 1'b1;
      amplifier_select_n = 1'b1;
      conv_start = 1'b0;
      continuous_mode = 1'b1;
      status_append_enable = 1'b0;
      status_bits = 8'ha5;
      raw_valid = 1'b0;
      raw_data = '0;
      n_errors = 0;
      total_checks = 0;
      n_rx = 0;
      repeat (20) @(negedge sys_clk);
      srst = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk({pin_oe, result_ready_n, new_data}, 3'b010);
      t_unread();
      t_sel();
      t_codes();
      t_fifo();
      final_report();
   end

   initial begin
      #100000;
      n_errors++;
      final_report();
   end
endmodule
